// ===== common/sfspi_defs.svh
// Constants of the serial flash front end: status fields, commands, timing.
`ifndef SFSPI_DEFS_SVH
`define SFSPI_DEFS_SVH

// ****************************************
// Status byte layout and reset values
// ****************************************
`define SFSPI_SR_BUSY        0
`define SFSPI_SR_WEL         1
`define SFSPI_SR_BP_LSB      2
`define SFSPI_SR_AAI         6
`define SFSPI_SR_LOCK        7
`define SFSPI_BP_RST         4'h7
`define SFSPI_LOCK_RST       1'h0

// ****************************************
// Command codes
// ****************************************
`define SFSPI_CMD_STATUS_WRITE 8'h01
`define SFSPI_CMD_STATUS_READ  8'h05

// ****************************************
// Erase granule address widths
// ****************************************
`define SFSPI_SECTOR_BITS    12
`define SFSPI_BLK32_BITS     15
`define SFSPI_BLK64_BITS     16

// ****************************************
// Timing
// ****************************************
`define SFSPI_MCLK_KHZ       20000
`define SFSPI_CHIP_ERASE_MS  35
`define SFSPI_SECT_ERASE_MS  18
`define SFSPI_BYTE_PROG_US   7
`define SFSPI_CHIP_ERASE_CYC (`SFSPI_CHIP_ERASE_MS * `SFSPI_MCLK_KHZ)
`define SFSPI_SECT_ERASE_CYC (`SFSPI_SECT_ERASE_MS * `SFSPI_MCLK_KHZ)
`define SFSPI_BYTE_PROG_CYC  ((`SFSPI_BYTE_PROG_US * `SFSPI_MCLK_KHZ) / 1000)

`endif

// ===== common/sfspi_pkg.sv
// Types shared by the serial flash front end.
package sfspi_pkg;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
    } sfspi_pins_t;

    typedef enum logic [2:0] {
        OP_BYTE   = 3'b000,
        OP_SECTOR = 3'b001,
        OP_BLK32  = 3'b010,
        OP_BLK64  = 3'b011,
        OP_CHIP   = 3'b100
    } sfspi_op_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_PAUSED = 2'b10
    } sfspi_state_t;

endpackage : sfspi_pkg

// ===== rtl/sfspi_fifo.sv
// Receive byte FIFO with registered output stage.
module sfspi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, pop;

    always_comb
    begin
        push = in_valid && (cnt_q != (AW+1)'(DEPTH));
        // Refill the output register whenever it is empty or being taken
        pop  = (cnt_q != '0) && (!ov_q || out_ready);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d = pop ? mem_q[rd_q] : od_q;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            ov_q     <= 1'b0;
            od_q     <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            wr_q     <= wr_d;
            rd_q     <= rd_d;
            cnt_q    <= cnt_d;
            ov_q     <= ov_d;
            od_q     <= od_d;
            in_ready <= cnt_d != (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end

    assign out_valid = ov_q;
    assign out_data  = od_q;

endmodule : sfspi_fifo

// ===== rtl/sfspi_front_end.sv
// Serial flash front end: pin sampling, byte framing, status byte and busy timer.
`include "sfspi_defs.svh"
module sfspi_front_end #(
    parameter int CHIP_ERASE_CYC = `SFSPI_CHIP_ERASE_CYC,
    parameter int SECT_ERASE_CYC = `SFSPI_SECT_ERASE_CYC
) (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic                cs_n,
    input  wire logic                sck,
    input  wire logic                si,
    input  wire logic                hold_n,
    input  wire logic                wp_n,
    output logic                     so_q,
    output logic                     so_oe_q,
    input  wire logic [7:0]          tx_byte,
    input  wire logic                auto_increment_program,
    input  wire logic                op_start,
    input  wire sfspi_pkg::sfspi_op_t op_kind,
    input  wire logic [23:0]         op_addr,
    output logic [23:0]              op_base_q,
    output logic                     busy_q,
    output logic [7:0]               status_q,
    output logic                     selected_q,
    output logic                     paused_q,
    output logic                     refused_q,
    output logic                     overrun_q,
    output logic                     rx_valid,
    input  wire logic                rx_ready,
    output logic [7:0]               rx_data
);
    localparam int BYTE_CYC = `SFSPI_BYTE_PROG_CYC;

    // ****************************************
    // Pin synchronisers and clock edges
    // ****************************************
    sfspi_pkg::sfspi_pins_t pins_s1_q, pins_s2_q, pins_in;
    logic                   sck_prev_q;
    logic                   sck_rise, sck_fall;

    assign pins_in  = '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
    // Rising and falling are both found on the second stage; only mode 3 has a fall before the first rise to put out the first bit
    assign sck_rise = pins_s2_q.sck && !sck_prev_q;
    assign sck_fall = !pins_s2_q.sck && sck_prev_q;

    // ****************************************
    // Framing state
    // ****************************************
    sfspi_pkg::sfspi_state_t state_q, state_d;
    logic [2:0]  bit_q, bit_d;
    logic [6:0]  sh_q, sh_d;
    logic [7:0]  cmd_q, cmd_d;
    logic [1:0]  idx_q, idx_d;
    logic [7:0]  tx_q, tx_d;
    logic        so_d, so_oe_d;
    logic [3:0]  bp_q, bp_d;
    logic        lock_q, lock_d;
    logic        refused_d;
    logic        push_q, push_d;
    logic [7:0]  push_data_q, push_data_d;
    logic        overrun_d;
    logic        fifo_ready;
    logic [7:0]  rx_byte;
    logic [7:0]  status_d;

    // ****************************************
    // Busy timer state
    // ****************************************
    logic        busy_d;
    logic [19:0] timer_q, timer_d;
    logic [23:0] base_d;

    assign rx_byte = {sh_q, pins_s2_q.si};

    always_comb
    begin
        state_d     = state_q;
        bit_d       = bit_q;
        sh_d        = sh_q;
        cmd_d       = cmd_q;
        idx_d       = idx_q;
        tx_d        = tx_q;
        so_d        = so_q;
        so_oe_d     = so_oe_q;
        bp_d        = bp_q;
        lock_d      = lock_q;
        refused_d   = 1'b0;
        push_d      = 1'b0;
        push_data_d = push_data_q;
        overrun_d   = overrun_q;
        if (pins_s2_q.cs_n)
        begin
            // Deselect clears framing even mid-hold
            state_d = sfspi_pkg::ST_IDLE;
            so_oe_d = 1'b0;
            bit_d   = 3'h0;
            idx_d   = 2'h0;
        end
        else
        begin
            unique case (state_q)
                sfspi_pkg::ST_IDLE:
                begin
                    state_d   = sfspi_pkg::ST_ACTIVE;
                    overrun_d = 1'b0;
                    tx_d      = tx_byte;
                end
                sfspi_pkg::ST_ACTIVE:
                begin
                    if (!pins_s2_q.sck && !pins_s2_q.hold_n)
                    begin
                        state_d = sfspi_pkg::ST_PAUSED;
                        so_oe_d = 1'b0;
                    end
                    else if (sck_rise)
                    begin
                        sh_d  = rx_byte[6:0];
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7)
                        begin
                            push_d      = 1'b1;
                            push_data_d = rx_byte;
                            idx_d       = (idx_q == 2'h2) ? idx_q : idx_q + 2'h1;
                            tx_d        = tx_byte;
                            if (idx_q == 2'h0)
                                cmd_d = rx_byte;
                            if ((idx_q == 2'h0 && rx_byte == `SFSPI_CMD_STATUS_READ) ||
                                (idx_q != 2'h0 && cmd_q == `SFSPI_CMD_STATUS_READ))
                                tx_d = status_q;
                            if (idx_q == 2'h1 && cmd_q == `SFSPI_CMD_STATUS_WRITE)
                            begin
                                if (!pins_s2_q.wp_n && lock_q)
                                    refused_d = 1'b1;
                                else
                                begin
                                    bp_d   = rx_byte[`SFSPI_SR_BP_LSB +: 4];
                                    lock_d = rx_byte[`SFSPI_SR_LOCK];
                                end
                            end
                        end
                    end
                    else if (sck_fall)
                    begin
                        so_oe_d = 1'b1;
                        if (auto_increment_program)
                            so_d = !busy_q;
                        else
                        begin
                            so_d = tx_q[7];
                            tx_d = {tx_q[6:0], 1'b0};
                        end
                    end
                end
                sfspi_pkg::ST_PAUSED:
                begin
                    // Clock and data are ignored here; output comes back at the next falling edge
                    if (!pins_s2_q.sck && pins_s2_q.hold_n)
                        state_d = sfspi_pkg::ST_ACTIVE;
                end
                default:
                begin
                    state_d = sfspi_pkg::ST_IDLE;
                end
            endcase
        end
        // A byte that finds the FIFO full is dropped and flagged; set wins over the frame-start clear
        if (push_q && !fifo_ready)
            overrun_d = 1'b1;
    end

    // Erase bases are aligned to their granule; a busy device ignores new starts
    always_comb
    begin
        busy_d  = busy_q;
        timer_d = timer_q;
        base_d  = op_base_q;
        if (!busy_q && op_start)
        begin
            busy_d = 1'b1;
            unique case (op_kind)
                sfspi_pkg::OP_BYTE:
                begin
                    timer_d = 20'(BYTE_CYC - 1);
                    base_d  = op_addr;
                end
                sfspi_pkg::OP_SECTOR:
                begin
                    timer_d = 20'(SECT_ERASE_CYC - 1);
                    base_d  = {op_addr[23:`SFSPI_SECTOR_BITS], `SFSPI_SECTOR_BITS'(0)};
                end
                sfspi_pkg::OP_BLK32:
                begin
                    timer_d = 20'(SECT_ERASE_CYC - 1);
                    base_d  = {op_addr[23:`SFSPI_BLK32_BITS], `SFSPI_BLK32_BITS'(0)};
                end
                sfspi_pkg::OP_BLK64:
                begin
                    timer_d = 20'(SECT_ERASE_CYC - 1);
                    base_d  = {op_addr[23:`SFSPI_BLK64_BITS], `SFSPI_BLK64_BITS'(0)};
                end
                sfspi_pkg::OP_CHIP:
                begin
                    timer_d = 20'(CHIP_ERASE_CYC - 1);
                    base_d  = 24'h000000;
                end
                default:
                begin
                    busy_d = 1'b0;
                end
            endcase
        end
        else if (busy_q)
        begin
            if (timer_q == 20'h00000)
                busy_d = 1'b0;
            else
                timer_d = timer_q - 20'h00001;
        end
        status_d = {lock_d, auto_increment_program, bp_d, 1'b0, busy_d};
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pins_s1_q   <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            pins_s2_q   <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
            sck_prev_q  <= 1'b0;
            state_q     <= sfspi_pkg::ST_IDLE;
            bit_q       <= 3'h0;
            sh_q        <= 7'h00;
            cmd_q       <= 8'h00;
            idx_q       <= 2'h0;
            tx_q        <= 8'h00;
            so_q        <= 1'b0;
            so_oe_q     <= 1'b0;
            bp_q        <= `SFSPI_BP_RST;
            lock_q      <= `SFSPI_LOCK_RST;
            refused_q   <= 1'b0;
            push_q      <= 1'b0;
            push_data_q <= 8'h00;
            overrun_q   <= 1'b0;
            busy_q      <= 1'b0;
            timer_q     <= 20'h00000;
            op_base_q   <= 24'h000000;
            status_q    <= {`SFSPI_LOCK_RST, 1'b0, `SFSPI_BP_RST, 2'b00};
            selected_q  <= 1'b0;
            paused_q    <= 1'b0;
        end
        else
        begin
            pins_s1_q   <= pins_in;
            pins_s2_q   <= pins_s1_q;
            sck_prev_q  <= pins_s2_q.sck;
            state_q     <= state_d;
            bit_q       <= bit_d;
            sh_q        <= sh_d;
            cmd_q       <= cmd_d;
            idx_q       <= idx_d;
            tx_q        <= tx_d;
            so_q        <= so_d;
            so_oe_q     <= so_oe_d;
            bp_q        <= bp_d;
            lock_q      <= lock_d;
            refused_q   <= refused_d;
            push_q      <= push_d;
            push_data_q <= push_data_d;
            overrun_q   <= overrun_d;
            busy_q      <= busy_d;
            timer_q     <= timer_d;
            op_base_q   <= base_d;
            status_q    <= status_d;
            selected_q  <= state_d != sfspi_pkg::ST_IDLE;
            paused_q    <= state_d == sfspi_pkg::ST_PAUSED;
        end
    end

    // ****************************************
    // Receive byte FIFO
    // ****************************************
    sfspi_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) u_rx_fifo (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (push_q),
        .in_ready  (fifo_ready),
        .in_data   (push_data_q),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

endmodule : sfspi_front_end

// ===== verification/sfspi_checker_assertions.sv
// Port-level assertions for the serial flash front end.
`include "sfspi_defs.svh"
module sfspi_checker #(
    parameter int CHIP_ERASE_CYC = 20,
    parameter int SECT_ERASE_CYC = 10
) (
    input wire logic                 mclk,
    input wire logic                 rst_b,
    input wire logic                 cs_n,
    input wire logic                 sck,
    input wire logic                 hold_n,
    input wire logic                 so_q,
    input wire logic                 so_oe_q,
    input wire logic                 auto_increment_program,
    input wire logic                 op_start,
    input wire sfspi_pkg::sfspi_op_t op_kind,
    input wire logic [23:0]          op_addr,
    input wire logic [23:0]          op_base_q,
    input wire logic                 busy_q,
    input wire logic [7:0]           status_q,
    input wire logic                 selected_q,
    input wire logic                 paused_q,
    input wire logic                 refused_q
);
    logic [31:0] cnt_q, cnt_d, len_q, len_d;
    logic [23:0] base_q, base_d;
    logic [5:0]  sck_q, sck_d, hold_q, hold_d;
    int          sh;

    always_comb
    begin
        sck_d = {sck_q[4:0], sck};
        hold_d = {hold_q[4:0], hold_n};
        cnt_d = busy_q ? cnt_q + 32'h1 : cnt_q;
        len_d = len_q;
        base_d = base_q;
        case (op_kind)
            sfspi_pkg::OP_BYTE:   sh = 0;
            sfspi_pkg::OP_SECTOR: sh = `SFSPI_SECTOR_BITS;
            sfspi_pkg::OP_BLK32:  sh = `SFSPI_BLK32_BITS;
            sfspi_pkg::OP_BLK64:  sh = `SFSPI_BLK64_BITS;
            default:              sh = 24;
        endcase
        if (op_start && !busy_q)
        begin
            cnt_d = 32'h0;
            len_d = (sh == 0) ? 32'h8C : (sh == 24) ? 32'(CHIP_ERASE_CYC) : 32'(SECT_ERASE_CYC);
            base_d = op_addr & ~((24'h1 << sh) - 24'h1);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            {cnt_q, len_q, base_q, sck_q, hold_q} <= '0;
        else
            {cnt_q, len_q, base_q, sck_q, hold_q} <= {cnt_d, len_d, base_d, sck_d, hold_d};
    end

    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    AST_DESEL_QUIET: assert property (cs_n [*5] |-> !so_oe_q && !selected_q && !paused_q)
        else $error("active while deselected");
    AST_SELECT: assert property ($fell(cs_n) && hold_n |-> ##[1:5] selected_q)
        else $error("select not taken");
    // Output moves 2 to 5 edges after a clock fall; a rise would be 4 edges further off
    AST_SO_EDGE: assert property (so_oe_q && $past(so_oe_q) && $changed(so_q) && !auto_increment_program
        |-> |(~sck_q[4:1] & sck_q[5:2])) else $error("output changed off a falling edge");
    AST_BUSY_START: assert property (op_start && !busy_q |=> busy_q ##[0:1] status_q[`SFSPI_SR_BUSY])
        else $error("busy not raised");
    AST_BUSY_LEN: assert property ($fell(busy_q) |-> cnt_q == len_q)
        else $error("busy length wrong");
    AST_OP_BASE: assert property ($rose(busy_q) |-> ##[0:1] op_base_q == base_q)
        else $error("erase base misaligned");
    AST_REFUSED: assert property (refused_q |-> status_q[`SFSPI_SR_LOCK] ##1 !refused_q)
        else $error("bad refusal");
    AST_PAUSE_OE: assert property (paused_q [*2] |-> !so_oe_q)
        else $error("output driven while paused");
    AST_PAUSE_ENTRY: assert property ($rose(paused_q) |-> selected_q && |(~hold_q[4:0] & ~sck_q[4:0]))
        else $error("pause without hold in clock low");
    AST_AAI_STATUS: assert property (auto_increment_program [*4] |-> status_q[`SFSPI_SR_AAI])
        else $error("mode bit not shown");
endmodule : sfspi_checker

bind sfspi_front_end sfspi_checker #(.CHIP_ERASE_CYC(CHIP_ERASE_CYC), .SECT_ERASE_CYC(SECT_ERASE_CYC)) i_chk (
    .mclk(mclk), .rst_b(rst_b), .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .so_q(so_q), .so_oe_q(so_oe_q),
    .auto_increment_program(auto_increment_program), .op_start(op_start), .op_kind(op_kind),
    .op_addr(op_addr), .op_base_q(op_base_q), .busy_q(busy_q), .status_q(status_q),
    .selected_q(selected_q), .paused_q(paused_q), .refused_q(refused_q)
);

// ===== verification/sfspi_master_model.sv
// Serial bus master model driving the flash front end pins.
module sfspi_master_model (
    input  wire logic so,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    timeunit 1ns;
    timeprecision 1ns;

    logic cpol = 1'b0;
    logic last = 1'b0;
    logic line;

    // A released output reads inverted, so a stale bit never passes
    assign line = so_oe ? so : ~last;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end

    task automatic open_frame(input logic mode3);
        cpol = mode3;
        sck = mode3;
        #200 cs_n = 1'b0;
        #200;
    endtask : open_frame

    task automatic close_frame();
        #200 cs_n = 1'b1;
        #400;
    endtask : close_frame

    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            if (cpol)
                sck = 1'b0;
            si = tx[i];
            #200 sck = 1'b1;
            rx[i] = line;
            last = line;
            #200;
            if (!cpol)
                sck = 1'b0;
        end
    endtask : xbyte

    // Clock and data wiggle while held; an even count leaves the clock where it started
    task automatic set_hold(input logic v);
        hold_n = v;
        #400;
        repeat (v ? 0 : 4)
        begin
            sck = ~sck;
            si = ~si;
            #200;
        end
    endtask : set_hold
endmodule : sfspi_master_model

// ===== verification/tb_sfspi_front_end.sv
// Self-checking bench for the serial flash front end.
module tb_sfspi_front_end;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CHIP = 20;
    localparam int SECT = 10;

    logic                 mclk = 1'b0;
    logic                 rst_b, cs_n, sck, si, hold_n, wp_n, so_q, so_oe_q, aip, op_start, busy_q;
    logic                 selected_q, paused_q, refused_q, overrun_q, rx_valid, rx_ready, stall;
    logic [7:0]           tx_byte, status_q, rx_data, rd;
    logic [23:0]          op_addr, op_base_q;
    sfspi_pkg::sfspi_op_t op_kind;
    logic [31:0]          seed = 32'hEA8C;
    logic [7:0]           rxq[$];
    logic                 lock = 1'b0;
    logic [3:0]           bp = 4'h7;
    logic [23:0]          am;
    int                   fails = 0, total_checks = 0, cyc = 0, nref = 0, n;

    always #25 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // The front end holds 17 bytes while stalled; later ones are lost
    task automatic send(input logic [7:0] tx);
        if (rxq.size() < 17)
            rxq.push_back(tx);
        m_host.xbyte(tx, rd);
    endtask : send

    task automatic swr(input logic [7:0] v);
        m_host.open_frame(1'b1);
        send(8'h01);
        send(v);
        m_host.close_frame();
        if (wp_n || !lock)
            {lock, bp} = {v[7], v[5:2]};
    endtask : swr

    task automatic idle();
        n = 0;
        while (busy_q === 1'b1 && n < 2000)
        begin
            @(posedge mclk);
            #7 n++;
        end
    endtask : idle

    always @(posedge mclk)
    begin
        cyc++;
        if (refused_q === 1'b1)
            nref++;
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            chk(32'(rx_data), rxq.size() ? 32'(rxq.pop_front()) : 32'h1FF);
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
        #7 rx_ready = !stall && ((rnd() & 32'h1) != 32'h0);
    end

    sfspi_master_model m_host (
        .so(so_q), .so_oe(so_oe_q), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n)
    );

    sfspi_front_end #(.CHIP_ERASE_CYC(CHIP), .SECT_ERASE_CYC(SECT)) i_sfspi_front_end (
        .mclk(mclk), .rst_b(rst_b), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n),
        .so_q(so_q), .so_oe_q(so_oe_q), .tx_byte(tx_byte), .auto_increment_program(aip),
        .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .op_base_q(op_base_q),
        .busy_q(busy_q), .status_q(status_q), .selected_q(selected_q), .paused_q(paused_q),
        .refused_q(refused_q), .overrun_q(overrun_q), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data)
    );

    initial
    begin
        rst_b = 1'b0;
        wp_n = 1'b1;
        tx_byte = 8'(rnd());
        aip = 1'b0;
        op_start = 1'b0;
        op_kind = sfspi_pkg::OP_BYTE;
        op_addr = 24'h0;
        stall = 1'b0;
        repeat (5) @(posedge mclk);
        #7 rst_b = 1'b1;
        chk(32'(status_q), 32'h1C);
        repeat (4) @(posedge mclk);
        #7 m_host.open_frame(1'b1);
        send(8'h05);
        chk(32'(rd), 32'(tx_byte));
        send(8'h5A);
        chk(32'(rd), 32'h1C);
        m_host.close_frame();
        chk(32'(overrun_q), 32'h0);
        m_host.open_frame(1'b0);
        send(8'(rnd()));
        m_host.set_hold(1'b0);
        chk(32'({paused_q, selected_q}), 32'h3);
        chk(32'(so_oe_q), 32'h0);
        m_host.set_hold(1'b1);
        send(8'(rnd()));
        m_host.set_hold(1'b0);
        m_host.close_frame();
        chk(32'({paused_q, selected_q}), 32'h0);
        m_host.set_hold(1'b1);
        swr(8'hA0);
        chk(32'(status_q), 32'({lock, aip, bp, 2'b00}));
        wp_n = 1'b0;
        swr(8'h00);
        chk(32'(nref), 32'h1);
        chk(32'(status_q), 32'hA0);
        wp_n = 1'b1;
        swr(8'h3C);
        chk(32'(status_q), 32'({lock, aip, bp, 2'b00}));
        for (int k = 0; k < 5; k++)
        begin
            op_kind = sfspi_pkg::sfspi_op_t'(k);
            op_addr = 24'(rnd());
            op_start = 1'b1;
            @(posedge mclk);
            #7 op_start = 1'b0;
            chk(32'(busy_q), 32'h1);
            // Granules: byte keeps all bits, then 4K, 32K, 64K, and the whole chip
            am = k == 0 ? 24'hFFFFFF : k == 1 ? 24'hFFF000 : k == 2 ? 24'hFF8000 : k == 3 ? 24'hFF0000 : 24'h000000;
            chk(32'(op_base_q), 32'(op_addr & am));
            idle();
            chk(n, k == 0 ? 140 : k == 4 ? CHIP : SECT);
        end
        aip = 1'b1;
        op_kind = sfspi_pkg::OP_BYTE;
        op_start = 1'b1;
        @(posedge mclk);
        #7 op_start = 1'b0;
        m_host.open_frame(1'b1);
        send(8'h00);
        chk(32'(rd), 32'h00);
        chk(32'(status_q[6]), 32'h1);
        idle();
        send(8'hFF);
        chk(32'(rd), 32'hFF);
        m_host.close_frame();
        aip = 1'b0;
        while (rxq.size() != 0)
            @(posedge mclk);
        #7 stall = 1'b1;
        @(posedge mclk);
        #7 m_host.open_frame(1'b0);
        repeat (18) send(8'(rnd()));
        m_host.close_frame();
        chk(32'(overrun_q), 32'h1);
        stall = 1'b0;
        repeat (300) @(posedge mclk);
        chk(32'(rxq.size()), 32'h0);
        wrap_up();
    end
endmodule : tb_sfspi_front_end
